//--- rtl/pstrc_power_ctrl.sv
// Power state sequencer with chip-wide reset control
`timescale 1ns/100ps
`include "pstrc_defines.svh"
module pstrc_power_ctrl
   import pstrc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic porPulse,
   input wire logic chipReset_n,
   input wire logic cmdValid,
   input wire logic [2:0] cmdCode,
   input wire logic dramBusy,
   output logic coreReset,
   output logic sysRegReset,
   output logic sysClkEn,
   output logic engineEn,
   output logic blockClkEn,
   output logic pllEn,
   output logic dramIfEn,
   output logic dramPowerDown,
   output logic dramSelfRefresh,
   output logic blockReset,
   output logic blockPowerEn,
   output logic hostPortEn,
   output logic pinHold,
   output logic [5:0] powerState
);
   logic pinSync;
   logic chipRstReq;
   logic [`PSTRC_CNT_W-1:0] initCnt;
   logic [`PSTRC_CNT_W-1:0] idleCnt;
   pstrc_state_t state;
   pstrc_state_t next_state;
   logic nextReset;
   logic nextSleep;
   logic nextActive;
   logic nextStandby;
   logic nextDeepOff;
   logic idleDone;

   // Reset pin comes from outside, synchronise first
   pstrc_sync uPinSync (
      .clk(clk),
      .rst(rst),
      .din(chipReset_n),
      .dout(pinSync)
   );

   // Pin and power-on share one reset target set; pulse width and
   // release timing are the host's to keep, not checked here
   assign chipRstReq = porPulse | ~pinSync; // RQ2 RQ3

   // State transitions; only defined commands act
   always_comb begin
      next_state = state;
      case (state)
         PSTRC_RESET: next_state = PSTRC_INIT;
         PSTRC_INIT: begin
            if (initCnt == `PSTRC_INIT_CYC) begin
               next_state = PSTRC_SLEEP; // RQ5
            end
         end
         PSTRC_SLEEP, PSTRC_ACTIVE, PSTRC_STANDBY, PSTRC_DEEPOFF: begin
            if (cmdValid) begin
               case (cmdCode)
                  `PSTRC_CMD_ACTIVE: next_state = PSTRC_ACTIVE; // RQ6 RQ19
                  `PSTRC_CMD_STANDBY: next_state = PSTRC_STANDBY; // RQ8
                  `PSTRC_CMD_SLEEP: next_state = PSTRC_SLEEP; // RQ8
                  `PSTRC_CMD_DEEPOFF: next_state = PSTRC_DEEPOFF; // RQ8
                  default: next_state = state; // RQ18
               endcase
            end
         end
         default: next_state = PSTRC_RESET;
      endcase
   end

   // State register; any chip reset restarts the boot
   always_ff @(posedge clk) begin
      if (rst || chipRstReq) begin
         state <= PSTRC_RESET; // RQ2 RQ3
      end else begin
         state <= next_state;
      end
   end

   // Boot initialisation delay
   always_ff @(posedge clk) begin
      if (rst || chipRstReq || state != PSTRC_INIT) begin
         initCnt <= '0;
      end else begin
         initCnt <= initCnt + `PSTRC_CNT_ONE;
      end
   end

   // Standby DRAM idle timer; any DRAM traffic restarts it
   always_ff @(posedge clk) begin
      if (rst || chipRstReq || state != PSTRC_STANDBY || dramBusy) begin
         idleCnt <= '0;
      end else if (idleCnt != `PSTRC_IDLE_CYC) begin
         idleCnt <= idleCnt + `PSTRC_CNT_ONE;
      end
   end

   // Next-state decodes; every output but hostPortEn registers one of them so that
   // all outputs but dramPowerDown change on the same edge as powerState
   assign nextReset = next_state == PSTRC_RESET;
   assign nextSleep = next_state == PSTRC_SLEEP;
   assign nextActive = next_state == PSTRC_ACTIVE;
   assign nextStandby = next_state == PSTRC_STANDBY;
   assign nextDeepOff = next_state == PSTRC_DEEPOFF;
   assign idleDone = idleCnt == `PSTRC_IDLE_CYC;

   // Core register reset; also held through deep-off
   always_ff @(posedge clk) begin
      if (rst) begin
         coreReset <= 1'b1;
      end else begin
         coreReset <= chipRstReq || nextReset || nextDeepOff; // RQ2 RQ3 RQ15
      end
   end

   // System register group reset; deep-off must not touch it
   always_ff @(posedge clk) begin
      if (rst) begin
         sysRegReset <= 1'b1;
      end else begin
         sysRegReset <= chipRstReq || nextReset; // RQ2 RQ15
      end
   end

   // Block reset; deep-off holds the blocks like a chip reset
   always_ff @(posedge clk) begin
      if (rst) begin
         blockReset <= 1'b1;
      end else begin
         blockReset <= chipRstReq || nextReset || nextDeepOff; // RQ13
      end
   end

   // Core clock stays off until the first activation
   always_ff @(posedge clk) begin
      if (rst || chipRstReq) begin
         sysClkEn <= 1'b0;
      end else begin
         sysClkEn <= nextActive; // RQ17 RQ10
      end
   end

   // Graphics, audio and touch engines, active only
   always_ff @(posedge clk) begin
      if (rst || chipRstReq) begin
         engineEn <= 1'b0;
      end else begin
         engineEn <= nextActive; // RQ7
      end
   end

   // Block clocks; standby keeps them so exit needs no clock restart
   always_ff @(posedge clk) begin
      if (rst || chipRstReq) begin
         blockClkEn <= 1'b0;
      end else begin
         blockClkEn <= nextActive || nextStandby; // RQ12
      end
   end

   // PLLs; kept in standby, off in sleep and deep-off
   always_ff @(posedge clk) begin
      if (rst || chipRstReq) begin
         pllEn <= 1'b0;
      end else begin
         pllEn <= nextActive || nextStandby; // RQ12
      end
   end

   // DRAM interface enable, same states as the PLLs
   always_ff @(posedge clk) begin
      if (rst || chipRstReq) begin
         dramIfEn <= 1'b0;
      end else begin
         dramIfEn <= nextActive || nextStandby; // RQ12
      end
   end

   // Active power-down only after a full idle period in standby; the
   // request drops at once when traffic returns
   always_ff @(posedge clk) begin
      if (rst || chipRstReq) begin
         dramPowerDown <= 1'b0;
      end else begin
         dramPowerDown <= state == PSTRC_STANDBY && nextStandby
            && idleDone && !dramBusy; // RQ9
      end
   end

   // Self-refresh for the whole of sleep
   always_ff @(posedge clk) begin
      if (rst || chipRstReq) begin
         dramSelfRefresh <= 1'b0;
      end else begin
         dramSelfRefresh <= nextSleep; // RQ11
      end
   end

   // Block supplies; any chip reset powers them back up
   always_ff @(posedge clk) begin
      if (rst || chipRstReq) begin
         blockPowerEn <= 1'b1;
      end else begin
         blockPowerEn <= !nextDeepOff; // RQ13
      end
   end

   // Host port never loses power, so a command can always wake the chip
   always_ff @(posedge clk) begin
      if (rst || chipRstReq) begin
         hostPortEn <= 1'b1;
      end else begin
         hostPortEn <= 1'b1; // RQ14
      end
   end

   // Pins frozen in standby and sleep
   always_ff @(posedge clk) begin
      if (rst || chipRstReq) begin
         pinHold <= 1'b0;
      end else begin
         pinHold <= nextStandby || nextSleep; // RQ16
      end
   end

   // State as seen from outside
   always_ff @(posedge clk) begin
      if (rst || chipRstReq) begin
         powerState <= PSTRC_RESET;
      end else begin
         powerState <= next_state;
      end
   end
endmodule // pstrc_power_ctrl

//--- shared/pstrc_defines.svh
// Constants for the power state and reset controller
//
// Overview of operation
// RQ1: Host holds reset pin low 214 us minimum.
// RQ2: Reset pin resets same logic as power-on.
// RQ3: Power-on pulse resets all core logic.
// RQ4: Host releases reset 5 ms after core supply.
// RQ5: After boot initialisation, rest in sleep.
// RQ6: Active host command moves device to active.
// RQ7: Engines run only while active.
// RQ8: Host may command standby, sleep or deep-off.
// RQ9: Standby: DRAM active power-down after idleness.
// RQ10: Standby: core clock gated, registers kept.
// RQ11: Entering sleep puts DRAM into self-refresh.
// RQ12: Sleep: DRAM interface, PLLs, block clocks off.
// RQ13: Deep-off: blocks held reset, supplies off.
// RQ14: Deep-off: host port stays powered, working.
// RQ15: Deep-off: all but system registers reset.
// RQ16: Leaving active for standby/sleep holds pins.
// RQ17: System clock enabled only after host activation.
// RQ18: Unknown state requests ignored, state kept.
// RQ19: Leave low power only by host command.
`ifndef PSTRC_DEFINES_SVH
`define PSTRC_DEFINES_SVH

// Host command codes
`define PSTRC_CMD_ACTIVE 3'h1
`define PSTRC_CMD_STANDBY 3'h2
`define PSTRC_CMD_SLEEP 3'h3
`define PSTRC_CMD_DEEPOFF 3'h4

// Times and cycle counts at 125 MHz
`define PSTRC_CLK_MHZ 125
`define PSTRC_RST_MIN_US 214
`define PSTRC_RST_MIN_CYC (`PSTRC_RST_MIN_US * `PSTRC_CLK_MHZ)
`define PSTRC_INIT_CYC 16'h0010
`define PSTRC_IDLE_CYC 16'h0100
`define PSTRC_CNT_W 16
`define PSTRC_CNT_ONE 16'h0001

`endif

//--- shared/pstrc_pkg.sv
// Types for the power state and reset controller
package pstrc_pkg;
   typedef enum logic [5:0] {
      PSTRC_RESET = 6'h01,
      PSTRC_INIT = 6'h02,
      PSTRC_SLEEP = 6'h04,
      PSTRC_ACTIVE = 6'h08,
      PSTRC_STANDBY = 6'h10,
      PSTRC_DEEPOFF = 6'h20
   } pstrc_state_t;
endpackage

//--- rtl/pstrc_sync.sv
// Two-stage synchroniser for an asynchronous level
`timescale 1ns/100ps
module pstrc_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic meta;

   // First stage read only by the second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= 1'b1;
         dout <= 1'b1;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // pstrc_sync

//--- tb/pstrc_power_ctrl_properties.sv
// Checker for the power state sequencer
`timescale 1ns/100ps
module pstrc_power_ctrl_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic porPulse,
   input wire logic chipReset_n,
   input wire logic cmdValid,
   input wire logic [2:0] cmdCode,
   input wire logic coreReset,
   input wire logic sysRegReset,
   input wire logic sysClkEn,
   input wire logic engineEn,
   input wire logic pllEn,
   input wire logic dramSelfRefresh,
   input wire logic blockPowerEn,
   input wire logic hostPortEn,
   input wire logic [5:0] powerState
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [5:0] want;
   // Target of a command, zero for an undefined code
   assign want = cmdCode == 3'h1 ? 6'h08 : cmdCode == 3'h2 ? 6'h10 :
      cmdCode == 3'h3 ? 6'h04 : cmdCode == 3'h4 ? 6'h20 : 6'h00;
   // Settled state, no reset pending
   sequence s_ready;
      powerState inside {6'h04, 6'h08, 6'h10, 6'h20} && chipReset_n && !porPulse;
   endsequence
   a_cmd_enter: assert property (
      s_ready ##0 (cmdValid && want != 6'h00) |=> powerState == $past(want))
      else $error("command missed");
   a_state_kept: assert property (
      s_ready ##0 !(cmdValid && want != 6'h00) |=> $stable(powerState))
      else $error("state moved alone");
   a_boot_sleep: assert property (
      powerState == 6'h02 ##1 !(powerState inside {6'h01, 6'h02}) |-> powerState == 6'h04)
      else $error("boot not in sleep");
   a_engine_active: assert property (
      engineEn || sysClkEn |-> powerState == 6'h08) else $error("clock outside active");
   a_sleep_dram: assert property (
      powerState == 6'h04 |-> dramSelfRefresh && !pllEn) else $error("sleep outputs");
   a_deepoff_hold: assert property (
      powerState == 6'h20 |-> coreReset && !sysRegReset && !blockPowerEn && hostPortEn)
      else $error("deep-off outputs");
   a_pin_reset: assert property (
      $fell(chipReset_n) ##1 !chipReset_n [*2] |=> sysRegReset && powerState == 6'h01)
      else $error("pin reset missed");
   a_por_reset: assert property (
      porPulse |=> coreReset && sysRegReset && powerState == 6'h01) else $error("por missed");
endmodule // pstrc_power_ctrl_properties

bind pstrc_power_ctrl pstrc_power_ctrl_properties u_props (.clk(clk), .rst(rst),
   .porPulse(porPulse), .chipReset_n(chipReset_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
   .coreReset(coreReset), .sysRegReset(sysRegReset), .sysClkEn(sysClkEn), .engineEn(engineEn),
   .pllEn(pllEn), .dramSelfRefresh(dramSelfRefresh), .blockPowerEn(blockPowerEn),
   .hostPortEn(hostPortEn), .powerState(powerState));

//--- tb/pstrc_host_model.sv
// Host controller model: reset pin and command strobe
`timescale 1ns/100ps
module pstrc_host_model (
   input wire logic clk,
   output logic chipReset_n,
   output logic cmdValid,
   output logic [2:0] cmdCode
);
   // Idle levels; supplies count as settled long before the first edge
   initial begin
      chipReset_n = 1'b1;
      cmdValid = 1'b0;
      cmdCode = 3'h7;
   end
   // One-cycle strobe; code bus shows junk when idle
   task automatic send(input logic [2:0] code);
      @(negedge clk);
      cmdValid = 1'b1;
      cmdCode = code;
      @(negedge clk);
      cmdValid = 1'b0;
      cmdCode = ~code;
   endtask
   // Full-length pin reset, slow but faithful
   task automatic pin_reset(input int cycles);
      @(negedge clk);
      chipReset_n = 1'b0;
      repeat (cycles) @(negedge clk);
      chipReset_n = 1'b1;
   endtask
endmodule // pstrc_host_model

//--- tb/test_pstrc_power_ctrl.sv
// Bench for the power state sequencer
`timescale 1ns/100ps
`include "pstrc_defines.svh"
module test_pstrc_power_ctrl;
   logic clk = 0, rst = 1, porPulse = 0, dramBusy = 0, chipReset_n, cmdValid, dramPowerDown;
   logic coreReset, sysRegReset, sysClkEn, engineEn, blockClkEn, pllEn, dramIfEn;
   logic dramSelfRefresh, blockReset, blockPowerEn, hostPortEn, pinHold;
   logic [11:0] outs;
   logic [2:0] cmdCode, code;
   logic [5:0] powerState, exp;
   int miscompares = 0, cmp_count = 0, seed = 32'hb2da;
   pstrc_host_model u_pstrc_host_model (.clk(clk), .chipReset_n(chipReset_n),
      .cmdValid(cmdValid), .cmdCode(cmdCode));
   pstrc_power_ctrl u_pstrc_power_ctrl (.clk(clk), .rst(rst), .porPulse(porPulse),
      .chipReset_n(chipReset_n), .cmdValid(cmdValid), .cmdCode(cmdCode), .dramBusy(dramBusy),
      .coreReset(coreReset), .sysRegReset(sysRegReset), .sysClkEn(sysClkEn),
      .engineEn(engineEn), .blockClkEn(blockClkEn), .pllEn(pllEn), .dramIfEn(dramIfEn),
      .dramPowerDown(dramPowerDown), .dramSelfRefresh(dramSelfRefresh),
      .blockReset(blockReset), .blockPowerEn(blockPowerEn), .hostPortEn(hostPortEn),
      .pinHold(pinHold), .powerState(powerState));
   // Static controls packed for one compare per state
   assign outs = {coreReset, sysRegReset, sysClkEn, engineEn, blockClkEn, pllEn, dramIfEn,
      dramSelfRefresh, blockReset, blockPowerEn, hostPortEn, pinHold};
   // 125 MHz clock
   initial forever #4 clk = ~clk;
   task automatic check(input logic [15:0] seen, input logic [15:0] wanted);
      cmp_count++;
      if (seen !== wanted) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, wanted);
      end
   endtask
   // Undefined codes leave the state alone
   function automatic logic [5:0] next_state(input logic [5:0] cur, input logic [2:0] c);
      return c == 3'h1 ? 6'h08 : c == 3'h2 ? 6'h10 : c == 3'h3 ? 6'h04 : c == 3'h4 ? 6'h20 : cur;
   endfunction
   // Controls each settled state asks for, in the order of outs
   function automatic logic [11:0] state_outs(input logic [5:0] s);
      case (s)
         6'h01: return 12'hc0e;
         6'h04: return 12'h017;
         6'h08: return 12'h3e6;
         6'h10: return 12'h0e7;
         6'h20: return 12'h80a;
         default: return 12'hfff;
      endcase
   endfunction
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Boot, every code then random ones, standby idleness, both resets
   initial begin
      repeat (16) @(negedge clk);
      rst = 0;
      repeat (20) @(negedge clk);
      check(powerState, 6'h04);
      check(outs, state_outs(6'h04));
      exp = 6'h04;
      for (int i = 0; i < 48; i++) begin
         code = i < 8 ? 3'(i) : 3'($random(seed));
         u_pstrc_host_model.send(code);
         exp = next_state(exp, code);
         check(powerState, exp);
         check(outs, state_outs(exp));
      end
      $display("commands done");
      u_pstrc_host_model.send(3'h1);
      u_pstrc_host_model.send(3'h2);
      repeat (250) @(negedge clk);
      check(dramPowerDown, 1'b0);
      repeat (10) @(negedge clk);
      check(dramPowerDown, 1'b1);
      check(powerState, 6'h10);
      check(outs, state_outs(6'h10));
      dramBusy = 1;
      repeat (2) @(negedge clk);
      check(dramPowerDown, 1'b0);
      $display("standby done");
      u_pstrc_host_model.pin_reset(`PSTRC_RST_MIN_CYC);
      check(powerState, 6'h01);
      check(outs, state_outs(6'h01));
      repeat (25) @(negedge clk);
      check(powerState, 6'h04);
      porPulse = 1;
      repeat (2) @(negedge clk);
      porPulse = 0;
      check(powerState, 6'h01);
      check(outs, state_outs(6'h01));
      repeat (25) @(negedge clk);
      check(powerState, 6'h04);
      $display("resets done");
      test_done();
   end
   // Watchdog sized from the reset hold plus traffic
   initial begin
      repeat (`PSTRC_RST_MIN_CYC + 5000) @(posedge clk);
      miscompares++;
      test_done();
   end
endmodule // test_pstrc_power_ctrl
